// [hw/ubst_pkg.sv]
// package: constants for the break/sync transmitter
// assumes: one 100 MHz clock, synchronous active-high reset
package ubst_pkg;
   localparam int DATA_W = 8;
   localparam int BREAK_ZEROS = 12;
   localparam int BAUD_DIV_DEF = 868;
   localparam int CLK_MHZ = 100;
   localparam logic [7:0] SYNC_BYTE = 8'h55;
   localparam logic TX_IDLE = 1'b1;
   localparam logic START_LVL = 1'b0;
   localparam logic STOP_LVL = 1'b1;
   localparam logic [3:0] FRAME_BITS_NORM = 4'h8;
   localparam logic [3:0] FRAME_BITS_BRK = 4'hC;
   typedef enum logic [1:0] {
      UBST_IDLE = 2'b00,
      UBST_START = 2'b01,
      UBST_DATA = 2'b10,
      UBST_STOP = 2'b11
   } ubst_state_t;
endpackage : ubst_pkg

// [hw/ubst_baud_gen.sv]
// baud tick generator: one-cycle pulse every div_i clocks
// assumes: div_i stable while the shifter is busy
`timescale 1ns/1ps
module ubst_baud_gen #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // control
   input wire logic run_i,
   input wire logic [CNT_W-1:0] div_i,
   // tick
   output logic tick_o
);
   logic [CNT_W-1:0] cnt_r;

   // refuse a counter too narrow to count a bit time
   if (CNT_W < 2) begin : g_bad_cnt
      $error("ubst_baud_gen: CNT_W too small");
   end

   // counts down while running, reloads from div_i at zero, the cycle after each tick
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || !run_i) begin
         cnt_r <= '0;
      end else if (cnt_r == '0) begin
         cnt_r <= div_i - CNT_W'(1);
      end else begin
         cnt_r <= cnt_r - CNT_W'(1);
      end
   end

   assign tick_o = run_i && (cnt_r == CNT_W'(1) || (div_i == CNT_W'(1)));
endmodule : ubst_baud_gen

// [hw/ubst_tx.sv]
// break-capable serial transmitter with one-byte holding register
// assumes: write strobe from logic on core_clk_i; lin slave on tx_o
`timescale 1ns/1ps
// Function
// - break is start bit, twelve zero bits, then stop bit at baud rate
// - break begins on holding-register write with break request and enable set
// - data written for a break is discarded; only zeros shifted
// - break request clears itself after the break stop bit completes
// - next byte is accepted into holding register while break shifts
// - shift-register-empty low while shifting, high when line idle
// - queued sync byte follows the break with no software action
// - transmit-buffer-empty flag sets when holding register frees
module ubst_tx #(
   parameter int BAUD_DIV = ubst_pkg::BAUD_DIV_DEF,
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // control bits
   input wire logic transmit_enable_bit_i,
   input wire logic break_request_set_i,
   output logic break_request_bit_o,
   // holding register write
   input wire logic thr_wr_i,
   input wire logic [ubst_pkg::DATA_W-1:0] thr_data_i,
   // status
   output logic transmit_buffer_empty_flag_o,
   output logic shift_register_empty_flag_o,
   // serial line
   output logic tx_o
);
   // shifter holds the longest data portion, the break
   localparam int SH_W = ubst_pkg::BREAK_ZEROS;

   // refuse settings the logic cannot serve
   if (CNT_W < 2 || CNT_W > 30) begin : g_bad_cnt
      $error("ubst_tx: bad CNT_W");
   end
   if (BAUD_DIV < 1 || BAUD_DIV >= (1 << CNT_W)) begin : g_bad_div
      $error("ubst_tx: bad BAUD_DIV");
   end
   if (ubst_pkg::DATA_W >= SH_W || SH_W > 15) begin : g_bad_frame
      $error("ubst_tx: frame does not fit the shifter");
   end
   if (ubst_pkg::FRAME_BITS_BRK != 4'(SH_W)) begin : g_bad_len
      $error("ubst_tx: break length and shifter width differ");
   end

   // frame state and holding register
   ubst_pkg::ubst_state_t state_r;
   logic brk_req_r;
   logic thr_full_r;
   logic thr_brk_r;
   logic [ubst_pkg::DATA_W-1:0] thr_r;
   // shifter and counters
   logic [SH_W-1:0] shreg_ld;
   wire logic [SH_W-1:0] shreg_bits;
   logic [3:0] bit_cnt_r;
   logic [3:0] bits_tot_r;
   logic shift_brk_r;
   logic tx_r;
   // frame events
   logic tick;
   logic load;
   logic stop_done;
   logic shift_en;
   logic last_bit;

   // baud tick runs only while a frame is on the line
   ubst_baud_gen #(.CNT_W(CNT_W)) u_baud (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .run_i(state_r != ubst_pkg::UBST_IDLE),
      .div_i(CNT_W'(BAUD_DIV)),
      .tick_o(tick)
   );

   // load from holding register, stop end, data shift and last data bit
   assign load = (state_r == ubst_pkg::UBST_IDLE) && thr_full_r && transmit_enable_bit_i;
   assign stop_done = (state_r == ubst_pkg::UBST_STOP) && tick;
   assign shift_en = (state_r == ubst_pkg::UBST_DATA) && tick;
   assign last_bit = shift_en && (bit_cnt_r == bits_tot_r - 4'h1);

   // shifter load value: zeros for a break, else the held byte
   assign shreg_ld = thr_brk_r ? '0
                     : {{(SH_W - ubst_pkg::DATA_W){1'b0}}, thr_r};

   // break request: software set, hardware clear after break stop bit
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         brk_req_r <= 1'b0;
      end else if (break_request_set_i) begin
         brk_req_r <= 1'b1;
      end else if (stop_done && shift_brk_r) begin
         brk_req_r <= 1'b0;
      end
   end

   // holding register; a write during a break is accepted
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         thr_full_r <= 1'b0;
         thr_brk_r <= 1'b0;
         thr_r <= '0;
      end else if (thr_wr_i && (!thr_full_r || load)) begin
         thr_full_r <= 1'b1;
         // break only if request set and no break already pending or shifting
         thr_brk_r <= brk_req_r && transmit_enable_bit_i
                      && !(thr_full_r && thr_brk_r) && !shift_brk_r;
         thr_r <= thr_data_i;
      end else if (load) begin
         thr_full_r <= 1'b0;
         thr_brk_r <= 1'b0;
      end
   end

   // frame state: idle, start bit, data bits, stop bit
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_r <= ubst_pkg::UBST_IDLE;
      end else begin
         unique case (state_r)
            ubst_pkg::UBST_IDLE: begin
               if (load) begin
                  state_r <= ubst_pkg::UBST_START;
               end
            end
            ubst_pkg::UBST_START: begin
               if (tick) begin
                  state_r <= ubst_pkg::UBST_DATA;
               end
            end
            ubst_pkg::UBST_DATA: begin
               if (last_bit) begin
                  state_r <= ubst_pkg::UBST_STOP;
               end
            end
            ubst_pkg::UBST_STOP: begin
               if (tick) begin
                  state_r <= ubst_pkg::UBST_IDLE;
               end
            end
         endcase
      end
   end

   // break mark of the frame in the shifter
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         shift_brk_r <= 1'b0;
      end else if (load) begin
         shift_brk_r <= thr_brk_r;
      end else if (stop_done) begin
         shift_brk_r <= 1'b0;
      end
   end

   // data bits in this frame: a byte or the break zeros
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         bits_tot_r <= ubst_pkg::FRAME_BITS_NORM;
      end else if (load) begin
         if (thr_brk_r) begin
            bits_tot_r <= ubst_pkg::FRAME_BITS_BRK;
         end else begin
            bits_tot_r <= ubst_pkg::FRAME_BITS_NORM;
         end
      end
   end

   // data bit counter, one step per tick in the data state
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || load) begin
         bit_cnt_r <= '0;
      end else if (shift_en) begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
      end
   end

   // one flop per shifter bit: load, then take the upper neighbour
   for (genvar b = 0; b < SH_W; b++) begin : g_shbit
      logic bit_r;
      logic fill;
      if (b == SH_W - 1) begin : g_top
         assign fill = 1'b0;
      end else begin : g_mid
         assign fill = shreg_bits[b + 1];
      end
      always_ff @(posedge core_clk_i) begin
         if (sys_rst_i) begin
            bit_r <= 1'b0;
         end else if (load) begin
            bit_r <= shreg_ld[b];
         end else if (shift_en) begin
            bit_r <= fill;
         end
      end
      assign shreg_bits[b] = bit_r;
   end

   // line level registered from state
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         tx_r <= ubst_pkg::TX_IDLE;
      end else begin
         unique case (state_r)
            ubst_pkg::UBST_START: tx_r <= ubst_pkg::START_LVL;
            ubst_pkg::UBST_DATA: tx_r <= shreg_bits[0];
            ubst_pkg::UBST_STOP: tx_r <= ubst_pkg::STOP_LVL;
            ubst_pkg::UBST_IDLE: tx_r <= ubst_pkg::TX_IDLE;
         endcase
      end
   end

   // status and line outputs
   assign tx_o = tx_r;
   assign break_request_bit_o = brk_req_r;
   assign transmit_buffer_empty_flag_o = !thr_full_r;
   assign shift_register_empty_flag_o = (state_r == ubst_pkg::UBST_IDLE);
endmodule : ubst_tx

// [testbench/ubst_tx_assertions.sv]
// checker: port assertions for ubst_tx
// assumes: bound into ubst_tx, one clock domain
`timescale 1ns/1ps
module ubst_tx_assertions #(
   parameter int BAUD_DIV = ubst_pkg::BAUD_DIV_DEF
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // watched inputs
   input wire logic transmit_enable_bit_i,
   input wire logic break_request_set_i,
   input wire logic thr_wr_i,
   // watched outputs
   input wire logic break_request_bit_o,
   input wire logic transmit_buffer_empty_flag_o,
   input wire logic shift_register_empty_flag_o,
   input wire logic tx_o
);
   wire logic sre = shift_register_empty_flag_o;
   wire logic brk = break_request_bit_o;
   logic [15:0] low_r;
   always_ff @(posedge core_clk_i) low_r <= (sys_rst_i | tx_o) ? 16'h0 : low_r + 16'h1;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence load_s; $fell(sre) ##1 !tx_o; endsequence
   sequence brk_end_s; $rose(tx_o) && brk; endsequence
   brk_len_a: assert property (brk_end_s |-> low_r == 13 * BAUD_DIV)
      else $error("break length wrong");
   low_max_a: assert property (low_r <= 13 * BAUD_DIV)
      else $error("line low too long");
   start_bit_a: assert property ($fell(sre) |-> load_s)
      else $error("no start bit after load");
   enable_hold_a: assert property (!transmit_enable_bit_i && sre |=> sre)
      else $error("loaded while disabled");
   idle_high_a: assert property (sre |-> tx_o)
      else $error("line low while idle");
   write_take_a: assert property (thr_wr_i && transmit_buffer_empty_flag_o |=>
      !transmit_buffer_empty_flag_o) else $error("write not taken");
   brk_clear_a: assert property ($fell(brk) |-> tx_o && $past(tx_o, BAUD_DIV - 1))
      else $error("break request cleared early");
   brk_set_a: assert property (break_request_set_i |=> brk)
      else $error("break request not set");
endmodule : ubst_tx_assertions
bind ubst_tx ubst_tx_assertions #(.BAUD_DIV(BAUD_DIV)) chk_u (
   .core_clk_i(core_clk_i),
   .sys_rst_i(sys_rst_i),
   .transmit_enable_bit_i(transmit_enable_bit_i),
   .break_request_set_i(break_request_set_i),
   .thr_wr_i(thr_wr_i),
   .break_request_bit_o(break_request_bit_o),
   .transmit_buffer_empty_flag_o(transmit_buffer_empty_flag_o),
   .shift_register_empty_flag_o(shift_register_empty_flag_o),
   .tx_o(tx_o)
);

// [testbench/ubst_lin_slave.sv]
// model: lin slave node decoding the serial line
// assumes: idle-high line, B clocks per bit
`timescale 1ns/1ps
module ubst_lin_slave #(parameter int B = 4) (
   // line in, decoded results out
   input wire logic core_clk_i, tx_i,
   output logic [7:0] byte_o = 8'h00,
   output int nbyte_o = 0, nbrk_o = 0, zeros_o = 0
);
   logic [9:0] sh;
   initial forever begin
      @(negedge tx_i);
      for (int i = 0; i < 10; i++) begin
         repeat (i == 0 ? B / 2 : B) @(posedge core_clk_i);
         sh[i] = tx_i;
      end
      if (sh[9]) begin
         byte_o = sh[8:1];
         nbyte_o++;
      end else begin
         zeros_o = 10;
         do begin
            repeat (B) @(posedge core_clk_i);
            zeros_o += int'(!tx_i);
         end while (!tx_i);
         nbrk_o++;
      end
   end
endmodule : ubst_lin_slave

// [testbench/tb_ubst_tx.sv]
// bench: break, sync and random bytes through ubst_tx
// assumes: lin slave model decodes the line
`timescale 1ns/1ps
module tb_ubst_tx;
   logic core_clk_i = 1'h0, sys_rst_i = 1'h1, transmit_enable_bit_i = 1'h1;
   logic break_request_set_i = 1'h0, thr_wr_i = 1'h0, break_request_bit_o, tx_o;
   logic transmit_buffer_empty_flag_o, shift_register_empty_flag_o;
   logic [7:0] thr_data_i = 8'h00, seen;
   logic [31:0] x = 32'h00010F1E;
   int miscompares = 0, checks_done = 0, nb, nk, zr, cyc = 0;
   ubst_tx #(.BAUD_DIV(4)) uut (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .transmit_enable_bit_i(transmit_enable_bit_i),
      .break_request_set_i(break_request_set_i),
      .break_request_bit_o(break_request_bit_o),
      .thr_wr_i(thr_wr_i),
      .thr_data_i(thr_data_i),
      .transmit_buffer_empty_flag_o(transmit_buffer_empty_flag_o),
      .shift_register_empty_flag_o(shift_register_empty_flag_o),
      .tx_o(tx_o)
   );
   ubst_lin_slave #(.B(4)) lin (.core_clk_i, .tx_i(tx_o), .byte_o(seen), .nbyte_o(nb),
      .nbrk_o(nk), .zeros_o(zr));
   initial forever #5 core_clk_i = ~core_clk_i;
   function automatic logic [31:0] rnd(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction : rnd
   task automatic chk(input string n, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   task automatic put(input logic [7:0] d);
      for (int i = 0; i < 300; i++) begin
         @(negedge core_clk_i);
         if (transmit_buffer_empty_flag_o === 1'h1) break;
      end
      chk("buffer free", transmit_buffer_empty_flag_o, 1'h1);
      @(posedge core_clk_i) {thr_wr_i, thr_data_i} <= {1'h1, d};
      @(posedge core_clk_i) thr_wr_i <= 1'h0;
   endtask : put
   task automatic rx(input int n);
      for (int i = 0; i < 900 && nb < n; i++) @(negedge core_clk_i);
      chk("frames", nb, n);
   endtask : rx
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   initial begin
      repeat (10) @(posedge core_clk_i);
      sys_rst_i <= 1'h0;
      @(negedge core_clk_i);
      chk("idle", {tx_o, shift_register_empty_flag_o, transmit_buffer_empty_flag_o,
         break_request_bit_o}, 4'hE);
      @(posedge core_clk_i) break_request_set_i <= 1'h1;
      @(posedge core_clk_i) break_request_set_i <= 1'h0;
      x = rnd(x);
      put(x[7:0] | 8'h81);
      put(ubst_pkg::SYNC_BYTE);
      @(negedge core_clk_i);
      chk("queued", {break_request_bit_o, transmit_buffer_empty_flag_o}, 2'h2);
      rx(1);
      chk("breaks", nk, 32'h1);
      chk("zeros", zr, ubst_pkg::BREAK_ZEROS + 1);
      chk("sync", seen, ubst_pkg::SYNC_BYTE);
      chk("cleared", break_request_bit_o, 1'h0);
      @(posedge core_clk_i) transmit_enable_bit_i <= 1'h0;
      put(8'hA5);
      repeat (20) @(negedge core_clk_i);
      chk("held", {shift_register_empty_flag_o, nb[1:0]}, 3'h5);
      @(posedge core_clk_i) transmit_enable_bit_i <= 1'h1;
      rx(2);
      chk("sent", seen, 8'hA5);
      for (int k = 3; k < 9; k++) begin
         x = rnd(x);
         put(x[7:0]);
         rx(k);
         chk("rand", seen, x[7:0]);
      end
      end_sim();
   end
endmodule : tb_ubst_tx
